// >>> hw/fls_pkg.sv
// Purpose: shared constants and types of the flag and load/store unit
// Assumes: 8-bit data, three 16-bit pointer pairs in the top registers
// Notes:   offsets are byte addresses on a 32-bit register bus
package fls_pkg;

  localparam int unsigned FLAGS_W   = 8;
  localparam int unsigned PADDR_W   = 8;
  localparam int unsigned PDATA_W   = 32;

  // condition flag positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  localparam logic [FLAGS_W-1:0] FLAGS_RST = 8'h00;

  // low register of each pointer pair
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;
  localparam logic [4:0] PTR_HI_STEP = 5'h01;

  // register map
  localparam logic [PADDR_W-1:0] OFS_FLAGS    = 8'h00;
  localparam logic [PADDR_W-1:0] OFS_STATUS   = 8'h04;
  localparam logic [PADDR_W-1:0] OFS_REG_SEL  = 8'h08;
  localparam logic [PADDR_W-1:0] OFS_REG_DATA = 8'h0c;

  localparam int unsigned STS_BUSY    = 0;
  localparam int unsigned STS_ILLEGAL = 1;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_FLAG_SET,
    OP_FLAG_CLR,
    OP_SET_HALF,
    OP_CLR_HALF,
    OP_SET_SIGNED,
    OP_CLR_SIGNED,
    OP_SET_OVF,
    OP_CLR_OVF,
    OP_BIT_TO_T,
    OP_T_TO_BIT,
    OP_IND_READ,
    OP_DISP_READ,
    OP_DIRECT_READ,
    OP_IND_WRITE
  } fls_op_t;

  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} fls_ptr_t;

  typedef enum logic [1:0] {AM_PLAIN, AM_POST_INC, AM_PRE_DEC} fls_amode_t;

  typedef enum logic {ST_IDLE, ST_MEM} fls_state_t;

  function automatic logic [4:0] ptrLoIdx(input fls_ptr_t s);
    case (s)
      PTR_X:   ptrLoIdx = PTR_X_LO;
      PTR_Y:   ptrLoIdx = PTR_Y_LO;
      default: ptrLoIdx = PTR_Z_LO;
    endcase
  endfunction

  function automatic logic [FLAGS_W-1:0] flagMask(input logic [2:0] idx);
    flagMask = FLAGS_W'(1) << idx;
  endfunction

endpackage

// >>> hw/fls_addr_gen.sv
// Purpose: effective address and pointer update of a data memory access
// Assumes: displacement is unsigned, direct address overrides pointer
// Notes:   purely combinational
module fls_addr_gen
  import fls_pkg::*;
#(
  parameter int unsigned ADDR_W = 16,
  parameter int unsigned DISP_W = 6
) (
  input  wire logic [ADDR_W-1:0] ptrVal,
  input  wire fls_amode_t        mode,
  input  wire logic [DISP_W-1:0] disp,
  input  wire logic              useDisp,
  input  wire logic              useDirect,
  input  wire logic [ADDR_W-1:0] directAddr,
  output logic      [ADDR_W-1:0] effAddr,
  output logic      [ADDR_W-1:0] ptrNext,
  output logic                   ptrUpdate
);

  logic [ADDR_W-1:0] ptrDec;
  logic [ADDR_W-1:0] ptrInc;

  assign ptrDec = ptrVal - ADDR_W'(1);
  assign ptrInc = ptrVal + ADDR_W'(1);

  always_comb begin
    if (useDirect) begin
      effAddr = directAddr;
    end else if (useDisp) begin
      effAddr = ptrVal + ADDR_W'(disp);
    end else if (mode == AM_PRE_DEC) begin
      effAddr = ptrDec;
    end else begin
      effAddr = ptrVal;
    end
  end

  assign ptrNext   = (mode == AM_PRE_DEC) ? ptrDec : ptrInc;
  assign ptrUpdate = !useDirect && !useDisp && (mode != AM_PLAIN);

endmodule

// >>> hw/fls_exec.sv
// Purpose: executes flag and data memory load/store operations
// Assumes: memRdata is valid in the cycle memRe is high
// Notes:   registers reached over APB
// Contract
// - set half-carry only, one cycle
// - clear half-carry only, one cycle
// - copy register bit into transfer flag
// - transfer flag into register bit, one cycle
// - set signed flag only, one cycle
// - clear signed flag only, one cycle
// - set overflow flag only, one cycle
// - clear overflow flag only, one cycle
// - load then increment pointer, two cycles
// - decrement pointer then load, two cycles
// - load pointer plus displacement, pointer kept
// - load from instruction address, two cycles
// - store then increment pointer, two cycles
// - decrement pointer then store, two cycles
//
// Design decisions made here: the address map and the APB interface to the registers.
module fls_exec
  import fls_pkg::*;
#(
  parameter int unsigned NUM_GPR = 32,
  parameter int unsigned ADDR_W  = 16,
  parameter int unsigned DISP_W  = 6
) (
  input  wire logic               core_clk,
  input  wire logic               reset,
  input  wire logic               opValid,
  input  wire fls_op_t            opCode,
  input  wire logic [4:0]         opReg,
  input  wire logic [2:0]         opBit,
  input  wire logic [2:0]         opFlag,
  input  wire fls_ptr_t           opPtr,
  input  wire fls_amode_t         opMode,
  input  wire logic [DISP_W-1:0]  opDisp,
  input  wire logic [ADDR_W-1:0]  opAddr,
  output logic                    opReady,
  output logic [ADDR_W-1:0]       memAddr,
  output logic                    memRe,
  output logic                    memWe,
  output logic [7:0]              memWdata,
  input  wire logic [7:0]         memRdata,
  output logic [FLAGS_W-1:0]      flagsOut,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PDATA_W-1:0] pwdata,
  output logic                    pready,
  output logic [PDATA_W-1:0]      prdata,
  output logic                    pslverr
);

  localparam int unsigned REG_W = $clog2(NUM_GPR);

  typedef logic [NUM_GPR-1:0][7:0] fls_gpr_t;

  typedef struct packed {
    fls_state_t           state;
    fls_gpr_t             gpr;
    logic [FLAGS_W-1:0]   flags;
    logic [ADDR_W-1:0]    memAddr;
    logic                 memRe;
    logic                 memWe;
    logic [7:0]           memWdata;
    logic [REG_W-1:0]     dst;
    logic                 isRead;
    logic                 ptrUpd;
    fls_ptr_t             ptrSel;
    logic [ADDR_W-1:0]    ptrNext;
    logic                 busyPrev;
    logic                 illegal;
    logic [REG_W-1:0]     regSel;
    logic [PDATA_W-1:0]   prdata;
    logic                 slvErr;
  } fls_core_t;

  fls_core_t st_r;
  fls_core_t st_nxt;

  function automatic logic [ADDR_W-1:0] readPtr(input fls_gpr_t g,
                                                input fls_ptr_t s);
    logic [4:0] lo;
    lo = ptrLoIdx(s);
    readPtr = {g[lo + PTR_HI_STEP], g[lo]};
  endfunction

  logic              accept;
  logic              memOp;
  logic              illegalOp;
  logic              isReadOp;
  logic              apbAccess;
  logic              apbWrite;
  logic [ADDR_W-1:0] ptrVal;
  logic [ADDR_W-1:0] effAddr;
  logic [ADDR_W-1:0] ptrNext;
  logic              ptrUpdate;
  logic [4:0]        updLo;

  assign opReady  = (st_r.state == ST_IDLE);
  assign accept   = opValid && opReady;
  assign memOp    = (opCode == OP_IND_READ) || (opCode == OP_DISP_READ) ||
                    (opCode == OP_DIRECT_READ) || (opCode == OP_IND_WRITE);
  assign isReadOp = (opCode != OP_IND_WRITE);
  // displacement only through the second and third pair
  assign illegalOp = memOp && (opCode != OP_DIRECT_READ) &&
                     ((opPtr != PTR_X && opPtr != PTR_Y && opPtr != PTR_Z) ||
                      (opCode == OP_DISP_READ && opPtr == PTR_X));
  assign ptrVal   = readPtr(st_r.gpr, opPtr);
  assign updLo    = ptrLoIdx(st_r.ptrSel);

  fls_addr_gen #(
    .ADDR_W (ADDR_W),
    .DISP_W (DISP_W)
  ) u_addr (
    .ptrVal     (ptrVal),
    .mode       (opMode),
    .disp       (opDisp),
    .useDisp    (opCode == OP_DISP_READ),
    .useDirect  (opCode == OP_DIRECT_READ),
    .directAddr (opAddr),
    .effAddr    (effAddr),
    .ptrNext    (ptrNext),
    .ptrUpdate  (ptrUpdate)
  );

  // bus waits while the core is or was just busy, so reads are coherent
  assign pready    = psel && penable && opReady && !opValid && !st_r.busyPrev;
  assign apbAccess = pready;
  assign apbWrite  = apbAccess && pwrite;

  always_comb begin
    st_nxt          = st_r;
    st_nxt.memRe    = 1'b0;
    st_nxt.memWe    = 1'b0;
    st_nxt.busyPrev = accept || (st_r.state == ST_MEM);

    // register bus capture and writes
    st_nxt.slvErr = 1'b0;
    case (paddr)
      OFS_FLAGS:    st_nxt.prdata = PDATA_W'(st_r.flags);
      OFS_STATUS: begin
        st_nxt.prdata              = '0;
        st_nxt.prdata[STS_BUSY]    = (st_r.state == ST_MEM);
        st_nxt.prdata[STS_ILLEGAL] = st_r.illegal;
      end
      OFS_REG_SEL:  st_nxt.prdata = PDATA_W'(st_r.regSel);
      OFS_REG_DATA: st_nxt.prdata = PDATA_W'(st_r.gpr[st_r.regSel]);
      default: begin
        st_nxt.prdata = '0;
        st_nxt.slvErr = 1'b1;
      end
    endcase
    if (apbWrite) begin
      case (paddr)
        OFS_FLAGS:    st_nxt.flags = pwdata[FLAGS_W-1:0];
        OFS_STATUS: begin
          if (pwdata[STS_ILLEGAL]) begin
            st_nxt.illegal = 1'b0;
          end
        end
        OFS_REG_SEL:  st_nxt.regSel = pwdata[REG_W-1:0];
        OFS_REG_DATA: st_nxt.gpr[st_r.regSel] = pwdata[7:0];
        default: ;
      endcase
    end

    case (st_r.state)
      ST_IDLE: begin
        if (accept) begin
          case (opCode)
            OP_FLAG_SET:   st_nxt.flags[opFlag] = 1'b1;
            OP_FLAG_CLR:   st_nxt.flags[opFlag] = 1'b0;
            OP_SET_HALF:   st_nxt.flags[FLAG_H] = 1'b1;
            OP_CLR_HALF:   st_nxt.flags[FLAG_H] = 1'b0;
            OP_SET_SIGNED: st_nxt.flags[FLAG_S] = 1'b1;
            OP_CLR_SIGNED: st_nxt.flags[FLAG_S] = 1'b0;
            OP_SET_OVF:    st_nxt.flags[FLAG_V] = 1'b1;
            OP_CLR_OVF:    st_nxt.flags[FLAG_V] = 1'b0;
            OP_BIT_TO_T:
              st_nxt.flags[FLAG_T] = st_r.gpr[opReg][opBit];
            OP_T_TO_BIT:
              st_nxt.gpr[opReg][opBit] = st_r.flags[FLAG_T];
            OP_IND_READ, OP_DISP_READ, OP_DIRECT_READ, OP_IND_WRITE: begin
              if (illegalOp) begin
                st_nxt.illegal = 1'b1;
              end else begin
                // address phase: pre-decrement already in effAddr
                st_nxt.state    = ST_MEM;
                st_nxt.memAddr  = effAddr;
                st_nxt.memRe    = isReadOp;
                st_nxt.memWe    = !isReadOp;
                st_nxt.memWdata = st_r.gpr[opReg];
                st_nxt.dst      = opReg;
                st_nxt.isRead   = isReadOp;
                st_nxt.ptrUpd   = ptrUpdate;
                st_nxt.ptrSel   = opPtr;
                st_nxt.ptrNext  = ptrNext;
              end
            end
            default: ;
          endcase
        end
      end
      ST_MEM: begin
        if (st_r.isRead) begin
          st_nxt.gpr[st_r.dst] = memRdata;
        end
        // pointer written last: it wins over a load into its own pair
        if (st_r.ptrUpd) begin
          {st_nxt.gpr[updLo + PTR_HI_STEP], st_nxt.gpr[updLo]} =
            st_r.ptrNext;
        end
        st_nxt.state = ST_IDLE;
      end
      default: st_nxt.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_r       <= '0;
      st_r.flags <= FLAGS_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign memAddr  = st_r.memAddr;
  assign memRe    = st_r.memRe;
  assign memWe    = st_r.memWe;
  assign memWdata = st_r.memWdata;
  assign flagsOut = st_r.flags;
  assign prdata   = st_r.prdata;
  assign pslverr  = pready && st_r.slvErr;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property pFlagForce(fls_op_t op, logic [2:0] idx, logic val);
    accept && opCode == op |=> opReady && st_r.flags[idx] == val &&
      (st_r.flags & ~flagMask(idx)) == ($past(st_r.flags) & ~flagMask(idx));
  endproperty

  sequence sMemOp(fls_op_t op, fls_amode_t m);
    accept && opCode == op && opMode == m && !illegalOp;
  endsequence

  hc_set_a: assert property (pFlagForce(OP_SET_HALF, FLAG_H, 1'b1))
    else $error("half-carry set wrong");
  hc_clr_a: assert property (pFlagForce(OP_CLR_HALF, FLAG_H, 1'b0))
    else $error("half-carry clear wrong");
  sign_set_a: assert property (pFlagForce(OP_SET_SIGNED, FLAG_S, 1'b1))
    else $error("signed flag set wrong");
  sign_clr_a: assert property (pFlagForce(OP_CLR_SIGNED, FLAG_S, 1'b0))
    else $error("signed flag clear wrong");
  ovf_set_a: assert property (pFlagForce(OP_SET_OVF, FLAG_V, 1'b1))
    else $error("overflow set wrong");
  ovf_clr_a: assert property (pFlagForce(OP_CLR_OVF, FLAG_V, 1'b0))
    else $error("overflow clear wrong");

  bit_to_t_a: assert property (
    accept && opCode == OP_BIT_TO_T |=> opReady &&
      st_r.flags[FLAG_T] == $past(st_r.gpr[opReg][opBit]) &&
      (st_r.flags & ~flagMask(FLAG_T)) ==
        ($past(st_r.flags) & ~flagMask(FLAG_T)))
    else $error("bit to transfer flag wrong");

  t_to_bit_a: assert property (
    accept && opCode == OP_T_TO_BIT |=> opReady &&
      st_r.gpr[$past(opReg)][$past(opBit)] == $past(st_r.flags[FLAG_T]) &&
      st_r.flags == $past(st_r.flags))
    else $error("transfer flag to bit wrong");

  idx_flag_a: assert property (
    accept && opCode == OP_FLAG_SET |=> opReady &&
      st_r.flags == ($past(st_r.flags) | flagMask($past(opFlag))))
    else $error("indexed flag set wrong");

  ld_post_a: assert property (
    sMemOp(OP_IND_READ, AM_POST_INC) |=> !opReady && st_r.memRe &&
      st_r.memAddr == $past(ptrVal) ##1 opReady &&
      readPtr(st_r.gpr, $past(opPtr, 2)) == $past(ptrVal, 2) + ADDR_W'(1) &&
      st_r.flags == $past(st_r.flags, 2))
    else $error("post-increment load wrong");

  ld_pre_a: assert property (
    sMemOp(OP_IND_READ, AM_PRE_DEC) |=> st_r.memRe &&
      st_r.memAddr == $past(ptrVal) - ADDR_W'(1) ##1 opReady &&
      readPtr(st_r.gpr, $past(opPtr, 2)) == $past(ptrVal, 2) - ADDR_W'(1) &&
      st_r.flags == $past(st_r.flags, 2))
    else $error("pre-decrement load wrong");

  ld_disp_a: assert property (
    accept && opCode == OP_DISP_READ && !illegalOp |=> st_r.memRe &&
      st_r.memAddr == $past(ptrVal) + ADDR_W'($past(opDisp)) ##1 opReady &&
      st_r.gpr[$past(opReg, 2)] == $past(memRdata) &&
      st_r.flags == $past(st_r.flags, 2))
    else $error("displacement load wrong");

  ld_direct_a: assert property (
    accept && opCode == OP_DIRECT_READ |=> !opReady && st_r.memRe &&
      st_r.memAddr == $past(opAddr) ##1 opReady &&
      st_r.gpr[$past(opReg, 2)] == $past(memRdata) &&
      st_r.flags == $past(st_r.flags, 2))
    else $error("direct load wrong");

  st_post_a: assert property (
    sMemOp(OP_IND_WRITE, AM_POST_INC) |=> st_r.memWe && !st_r.memRe &&
      st_r.memWdata == $past(st_r.gpr[opReg]) &&
      st_r.memAddr == $past(ptrVal) ##1 opReady &&
      readPtr(st_r.gpr, $past(opPtr, 2)) == $past(ptrVal, 2) + ADDR_W'(1))
    else $error("post-increment store wrong");

  st_pre_a: assert property (
    sMemOp(OP_IND_WRITE, AM_PRE_DEC) |=> st_r.memWe &&
      st_r.memAddr == $past(ptrVal) - ADDR_W'(1) ##1 opReady &&
      st_r.flags == $past(st_r.flags, 2))
    else $error("pre-decrement store wrong");

  idx_clr_a: assert property (
    accept && opCode == OP_FLAG_CLR |=> opReady &&
      st_r.flags == ($past(st_r.flags) & ~flagMask($past(opFlag))))
    else $error("indexed flag clear wrong");

  disp_x_a: assert property (
    accept && opCode == OP_DISP_READ && opPtr == PTR_X |=> opReady &&
      st_r.illegal && !st_r.memRe && !st_r.memWe)
    else $error("displacement through first pair not refused");

  strobe_pulse_a: assert property (
    st_r.memRe || st_r.memWe |=> !st_r.memRe && !st_r.memWe)
    else $error("memory strobe longer than one cycle");

  // busy for exactly the access cycle, idle again after it
  sequence sTwoCycle;
    !opReady ##1 opReady;
  endsequence

  mem_two_cyc_a: assert property (
    accept && memOp && !illegalOp |=> sTwoCycle)
    else $error("memory operation length wrong");

endmodule

// >>> verification/test_flag_and_load_store_exec.sv
// Purpose: self-checking bench for the flag and load/store unit
// Assumes: data memory answers at once from memAddr
// Notes:   registers reached over APB, one task per bus cycle
module test_flag_and_load_store_exec
  import fls_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic        core_clk, reset, opValid, opReady;
  fls_op_t     opCode;
  logic [4:0]  opReg, lo;
  logic [2:0]  opBit, opFlag;
  fls_ptr_t    opPtr, p;
  fls_amode_t  opMode, m;
  logic [5:0]  opDisp;
  logic [15:0] opAddr, memAddr, seenAddr, ptr, ea, np;
  logic        memRe, memWe, seenRe, seenWe, psel, penable, pwrite;
  logic        pready, pslverr, err;
  logic [7:0]  memWdata, memRdata, seenWd, flagsOut, paddr, fl;
  logic [31:0] pwdata, prdata, rd;
  int          mismatches, total_checks;

  fls_op_t    namedOp [6] = '{OP_SET_HALF, OP_CLR_HALF, OP_SET_SIGNED,
                              OP_CLR_SIGNED, OP_SET_OVF, OP_CLR_OVF};
  logic [2:0] namedBit [6] = '{FLAG_H, FLAG_H, FLAG_S, FLAG_S,
                               FLAG_V, FLAG_V};

  function automatic logic [7:0] memf(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction

  assign memRdata = memf(memAddr);

  fls_exec dut (
    .core_clk(core_clk), .reset(reset), .opValid(opValid),
    .opCode(opCode), .opReg(opReg), .opBit(opBit), .opFlag(opFlag),
    .opPtr(opPtr), .opMode(opMode), .opDisp(opDisp), .opAddr(opAddr),
    .opReady(opReady), .memAddr(memAddr), .memRe(memRe), .memWe(memWe),
    .memWdata(memWdata), .memRdata(memRdata), .flagsOut(flagsOut),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic apb(input logic [7:0] a, input logic wr,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    check(n < 50, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic setReg(input logic [4:0] i, input logic [7:0] v);
    apb(OFS_REG_SEL, 1'b1, {27'h0, i});
    apb(OFS_REG_DATA, 1'b1, {24'h0, v});
  endtask

  task automatic getReg(input logic [4:0] i);
    apb(OFS_REG_SEL, 1'b1, {27'h0, i});
    apb(OFS_REG_DATA, 1'b0, 32'h0);
  endtask

  // hold the request until taken, then sample the strobes of ST_MEM
  task automatic doOp(input fls_op_t c, input logic [4:0] r,
                      input logic [2:0] b, input fls_ptr_t q,
                      input fls_amode_t md, input logic [15:0] a,
                      input logic mem);
    int n;
    n = 0;
    opValid <= 1'b1;
    opCode <= c;
    opReg <= r;
    opBit <= b;
    opFlag <= b;
    opPtr <= q;
    opMode <= md;
    opDisp <= a[5:0];
    opAddr <= a;
    do begin
      @(posedge core_clk);
      n++;
    end while (opReady !== 1'b1 && n < 20);
    opValid <= 1'b0;
    check(n < 20, 1'b1);
    @(posedge core_clk);
    check(opReady, !mem);
    seenAddr = memAddr;
    seenRe = memRe;
    seenWe = memWe;
    seenWd = memWdata;
    if (mem) begin
      @(posedge core_clk);
      check({opReady, memRe, memWe}, 3'b100);
    end
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    conclude();
  end

  initial begin
    reset = 1'b1;
    opValid = 1'b0;
    opCode = OP_NOP;
    {opReg, opBit, opFlag, opDisp, opAddr} = '0;
    opPtr = PTR_X;
    opMode = AM_PLAIN;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    apb(OFS_FLAGS, 1'b0, 32'h0);
    check(rd, {24'h0, FLAGS_RST});
    for (int i = 0; i < 6; i++) begin
      apb(OFS_FLAGS, 1'b1, (i % 2) ? 32'hff : 32'h00);
      doOp(namedOp[i], 5'h00, 3'h0, PTR_X, AM_PLAIN, 16'h0, 1'b0);
      fl = 8'h01 << namedBit[i];
      if (i % 2) fl = ~fl;
      check(flagsOut, fl);
    end
    apb(OFS_FLAGS, 1'b1, 32'ha5);
    for (int f = 0; f < 8; f++) begin
      fl = 8'h01 << f;
      doOp(OP_FLAG_SET, 5'h00, f[2:0], PTR_X, AM_PLAIN, 16'h0, 1'b0);
      check(flagsOut, 8'ha5 | fl);
      doOp(OP_FLAG_CLR, 5'h00, f[2:0], PTR_X, AM_PLAIN, 16'h0, 1'b0);
      check(flagsOut, 8'ha5 & ~fl);
      apb(OFS_FLAGS, 1'b1, 32'ha5);
    end
    setReg(5'h05, 8'h6c);
    apb(OFS_FLAGS, 1'b1, 32'hbf);
    for (int b = 0; b < 8; b++) begin
      doOp(OP_BIT_TO_T, 5'h05, b[2:0], PTR_X, AM_PLAIN, 16'h0, 1'b0);
      fl = 8'h6c;
      check(flagsOut, {1'b1, fl[b], 6'h3f});
    end
    doOp(OP_FLAG_SET, 5'h00, FLAG_T, PTR_X, AM_PLAIN, 16'h0, 1'b0);
    doOp(OP_T_TO_BIT, 5'h07, 3'h3, PTR_X, AM_PLAIN, 16'h0, 1'b0);
    check(flagsOut, 8'hff);
    doOp(OP_FLAG_CLR, 5'h00, FLAG_T, PTR_X, AM_PLAIN, 16'h0, 1'b0);
    doOp(OP_T_TO_BIT, 5'h05, 3'h2, PTR_X, AM_PLAIN, 16'h0, 1'b0);
    getReg(5'h07);
    check(rd, 32'h08);
    getReg(5'h05);
    check(rd, 32'h68);
    for (int k = 0; k < 2; k++) begin
      for (int pi = 0; pi < 3; pi++) begin
        for (int mi = 0; mi < 3; mi++) begin
          p = fls_ptr_t'(pi);
          m = fls_amode_t'(mi);
          lo = 5'h1a + {2'b00, pi[1:0], 1'b0};
          ptr = {6'h01, pi[1:0], (m == AM_PRE_DEC) ? 8'h00 : 8'hff};
          ea = (m == AM_PRE_DEC) ? ptr - 16'h0001 : ptr;
          np = (m == AM_POST_INC) ? ptr + 16'h0001 : ea;
          setReg(lo, ptr[7:0]);
          setReg(lo + 5'h01, ptr[15:8]);
          setReg(5'h02, 8'hc3);
          fl = flagsOut;
          doOp(k ? OP_IND_WRITE : OP_IND_READ, 5'h02, 3'h0, p, m, 16'h0,
               1'b1);
          check(seenAddr, ea);
          check({seenRe, seenWe}, k ? 2'b01 : 2'b10);
          if (k) check(seenWd, 8'hc3);
          check(flagsOut, fl);
          getReg(5'h02);
          check(rd, k ? 32'hc3 : {24'h0, memf(ea)});
          getReg(lo);
          check(rd, {24'h0, np[7:0]});
          getReg(lo + 5'h01);
          check(rd, {24'h0, np[15:8]});
        end
      end
    end
    setReg(5'h1c, 8'hc1);
    setReg(5'h1d, 8'h0f);
    doOp(OP_DISP_READ, 5'h04, 3'h0, PTR_Y, AM_PLAIN, 16'h003f, 1'b1);
    check(seenAddr, 16'h1000);
    getReg(5'h04);
    check(rd, {24'h0, memf(16'h1000)});
    getReg(5'h1c);
    check(rd, 32'hc1);
    doOp(OP_DIRECT_READ, 5'h09, 3'h0, PTR_X, AM_PLAIN, 16'hbeef, 1'b1);
    check(seenAddr, 16'hbeef);
    getReg(5'h09);
    check(rd, {24'h0, memf(16'hbeef)});
    doOp(OP_DISP_READ, 5'h04, 3'h0, PTR_X, AM_PLAIN, 16'h0001, 1'b0);
    check(seenRe, 1'b0);
    apb(OFS_STATUS, 1'b0, 32'h0);
    check(rd, 32'h2);
    apb(OFS_STATUS, 1'b1, 32'h2);
    apb(OFS_STATUS, 1'b0, 32'h0);
    check(rd, 32'h0);
    apb(8'h10, 1'b0, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    conclude();
  end
endmodule
